// File: hw/bsctap_top.v
`timescale 1ns/100ps
`default_nettype none
`include "bsctap_consts.vh"

module bsctap_top #(
  parameter [3:0]  ID_VERSION = 4'ha,    // arbitrary value
  parameter [15:0] ID_PART    = 16'h5a5a, // arbitrary value
  parameter [10:0] ID_MAKER   = 11'h0aa  // arbitrary value
) (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output reg         tdo,
  output reg         tdo_oe,
  input  wire [11:0] core_out,
  input  wire [11:0] core_oe,
  input  wire [11:0] pad_in,
  output reg  [11:0] pad_out,
  output reg  [11:0] pad_oe,
  input  wire [31:0] user_id_bytes,
  output reg         host_if_off,
  output reg  [6:0]  reg_addr,
  output reg  [7:0]  reg_wdata,
  output reg         reg_we,
  input  wire [7:0]  reg_rdata
);

  localparam [3:0] S_TLR   = 4'h0;
  localparam [3:0] S_RTI   = 4'h1;
  localparam [3:0] S_SELDR = 4'h2;
  localparam [3:0] S_CAPDR = 4'h3;
  localparam [3:0] S_SHDR  = 4'h4;
  localparam [3:0] S_EX1DR = 4'h5;
  localparam [3:0] S_PADR  = 4'h6;
  localparam [3:0] S_EX2DR = 4'h7;
  localparam [3:0] S_UPDR  = 4'h8;
  localparam [3:0] S_SELIR = 4'h9;
  localparam [3:0] S_CAPIR = 4'ha;
  localparam [3:0] S_SHIR  = 4'hb;
  localparam [3:0] S_EX1IR = 4'hc;
  localparam [3:0] S_PAIR  = 4'hd;
  localparam [3:0] S_EX2IR = 4'he;
  localparam [3:0] S_UPIR  = 4'hf;

  wire [2:0]  jtag_s;
  wire [11:0] pad_in_s;
  wire        tck_s;
  wire        tms_s;
  wire        tdi_s;
  reg         tck_d;
  wire        rise;
  wire        fall;
  reg  [3:0]  state;
  wire [3:0]  next_state;
  reg  [3:0]  ir;
  reg  [3:0]  ir_sh;
  reg  [31:0] dr_sh;
  reg  [31:0] next_dr_sh;
  reg  [23:0] upd;
  reg  [23:0] cap;
  reg  [11:0] next_pad_out;
  reg  [11:0] next_pad_oe;
  wire [5:0]  len;
  integer     i;

  function [3:0] tap_next;
    input [3:0] st;
    input       m;
    begin
      case (st)
        S_TLR:   tap_next = m ? S_TLR   : S_RTI;
        S_RTI:   tap_next = m ? S_SELDR : S_RTI;
        S_SELDR: tap_next = m ? S_SELIR : S_CAPDR;
        S_CAPDR: tap_next = m ? S_EX1DR : S_SHDR;
        S_SHDR:  tap_next = m ? S_EX1DR : S_SHDR;
        S_EX1DR: tap_next = m ? S_UPDR  : S_PADR;
        S_PADR:  tap_next = m ? S_EX2DR : S_PADR;
        S_EX2DR: tap_next = m ? S_UPDR  : S_SHDR;
        S_UPDR:  tap_next = m ? S_SELDR : S_RTI;
        S_SELIR: tap_next = m ? S_TLR   : S_CAPIR;
        S_CAPIR: tap_next = m ? S_EX1IR : S_SHIR;
        S_SHIR:  tap_next = m ? S_EX1IR : S_SHIR;
        S_EX1IR: tap_next = m ? S_UPIR  : S_PAIR;
        S_PAIR:  tap_next = m ? S_EX2IR : S_PAIR;
        S_EX2IR: tap_next = m ? S_UPIR  : S_SHIR;
        S_UPIR:  tap_next = m ? S_SELDR : S_RTI;
        default: tap_next = S_TLR;
      endcase
    end
  endfunction

  // length of the chain between data in and data out
  function [5:0] dr_len;
    input [3:0] code;
    begin
      case (code)
        `BSCTAP_IR_SAMPLE:   dr_len = `BSCTAP_LEN_BSR;
        `BSCTAP_IR_EXTEST:   dr_len = `BSCTAP_LEN_BSR;
        `BSCTAP_IR_IDCODE:   dr_len = `BSCTAP_LEN_CODE;
        `BSCTAP_IR_USERCODE: dr_len = `BSCTAP_LEN_CODE;
        `BSCTAP_IR_IFONOFF:  dr_len = `BSCTAP_LEN_IFONOFF;
        `BSCTAP_IR_REGRD:    dr_len = `BSCTAP_LEN_REGRD;
        `BSCTAP_IR_REGWR:    dr_len = `BSCTAP_LEN_REGWR;
        default:             dr_len = `BSCTAP_LEN_BYPASS;
      endcase
    end
  endfunction

  bsctap_sync #(.W(3)) u_sync_jtag (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       ({tck, tms, tdi}),
    .q       (jtag_s)
  );

  bsctap_sync #(.W(12)) u_sync_pad (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       (pad_in),
    .q       (pad_in_s)
  );

  assign tck_s = jtag_s[2];
  assign tms_s = jtag_s[1];
  assign tdi_s = jtag_s[0];

  // tap state and registers move only on test clock edges; pad outputs and reg_we update every system clock
  assign rise = tck_s & ~tck_d;
  assign fall = ~tck_s & tck_d;
  // tms is sampled well after the controller's falling-edge change
  assign next_state = tap_next(state, tms_s);
  assign len = dr_len(ir);

  // capture image: even cells see the pad, odd cells the core enable, but cell 7 sees core_out bit 4
  always @* begin
    for (i = 0; i < `BSCTAP_PADS; i = i + 1) begin
      cap[2*i]   = pad_in_s[i];
      cap[2*i+1] = core_oe[i];
    end
    cap[`BSCTAP_EXTRA_CELL] = core_out[`BSCTAP_EXTRA_PAD];
  end

  // shift by one within the active length, tdi enters at the top
  always @* begin
    next_dr_sh = 32'h00000000;
    for (i = 0; i < `BSCTAP_DR_W; i = i + 1) begin
      if (i == len - 1)
        next_dr_sh[i] = tdi_s;
      else if (i < len - 1)
        next_dr_sh[i] = dr_sh[i+1];
    end
  end

  // pads follow the core except while a test instruction owns them
  always @* begin
    next_pad_out = core_out;
    next_pad_oe  = core_oe;
    if (ir == `BSCTAP_IR_EXTEST || ir == `BSCTAP_IR_CLAMP) begin
      for (i = 0; i < `BSCTAP_PADS; i = i + 1) begin
        next_pad_out[i] = upd[2*i];
        next_pad_oe[i]  = upd[2*i+1];
      end
      // the pin behind cell 6 is input only; cell 7 drives the output value of pad 4
      next_pad_oe[`BSCTAP_INPUT_PAD]  = 1'b0;
      next_pad_out[`BSCTAP_EXTRA_PAD] = upd[`BSCTAP_EXTRA_CELL];
    end else if (ir == `BSCTAP_IR_HIGHZ) begin
      next_pad_oe = 12'h000;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tck_d       <= 1'b1;
      state       <= S_TLR;
      ir          <= `BSCTAP_IR_IDCODE;
      ir_sh       <= 4'h0;
      dr_sh       <= 32'h00000000;
      upd         <= 24'h000000;
      tdo         <= 1'b0;
      tdo_oe      <= 1'b0;
      pad_out     <= 12'h000;
      pad_oe      <= 12'h000;
      host_if_off <= 1'b0;
      reg_addr    <= 7'h00;
      reg_wdata   <= 8'h00;
      reg_we      <= 1'b0;
    end else begin
      tck_d   <= tck_s;
      pad_out <= next_pad_out;
      pad_oe  <= next_pad_oe;
      reg_we  <= 1'b0;
      if (rise) begin
        state <= next_state;
        if (state == S_TLR || next_state == S_TLR)
          ir <= `BSCTAP_IR_IDCODE;
        case (state)
          S_CAPIR: ir_sh <= `BSCTAP_IR_CAPTURE;
          S_SHIR:  ir_sh <= {tdi_s, ir_sh[3:1]};
          S_CAPDR: begin
            case (ir)
              `BSCTAP_IR_SAMPLE:   dr_sh <= {8'h00, cap};
              `BSCTAP_IR_EXTEST:   dr_sh <= {8'h00, cap};
              `BSCTAP_IR_IDCODE:
                dr_sh <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
              `BSCTAP_IR_USERCODE: dr_sh <= user_id_bytes;
              `BSCTAP_IR_REGRD:
                dr_sh <= {24'h000000,
                          host_if_off ? reg_rdata : 8'h00};
              default:             dr_sh <= 32'h00000000;
            endcase
          end
          S_SHDR:  dr_sh <= next_dr_sh;
          default: ;
        endcase
      end
      if (fall) begin
        // output is only driven while a chain is being shifted
        if (state == S_SHIR) begin
          tdo    <= ir_sh[0];
          tdo_oe <= 1'b1;
        end else if (state == S_SHDR) begin
          tdo    <= dr_sh[0];
          tdo_oe <= 1'b1;
        end else begin
          tdo    <= 1'b0;
          tdo_oe <= 1'b0;
        end
        if (state == S_UPIR)
          ir <= ir_sh;
        if (state == S_UPDR) begin
          case (ir)
            `BSCTAP_IR_SAMPLE:  upd <= dr_sh[23:0];
            `BSCTAP_IR_EXTEST:  upd <= dr_sh[23:0];
            `BSCTAP_IR_IFONOFF: host_if_off <= dr_sh[0];
            `BSCTAP_IR_REGRD:   reg_addr <= dr_sh[6:0];
            `BSCTAP_IR_REGWR: begin
              if (host_if_off) begin
                reg_addr  <= dr_sh[6:0];
                reg_wdata <= dr_sh[14:7];
                reg_we    <= 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: hw/bsctap_consts.vh
`ifndef BSCTAP_CONSTS_VH
`define BSCTAP_CONSTS_VH

// instruction codes, 4-bit instruction register
`define BSCTAP_IR_W        4
`define BSCTAP_IR_BYPASS   4'h0
`define BSCTAP_IR_SAMPLE   4'h1
`define BSCTAP_IR_IDCODE   4'h2
`define BSCTAP_IR_USERCODE 4'h3
`define BSCTAP_IR_CLAMP    4'h4
`define BSCTAP_IR_HIGHZ    4'h5
`define BSCTAP_IR_EXTEST   4'h7
`define BSCTAP_IR_IFONOFF  4'h8
`define BSCTAP_IR_REGRD    4'h9
`define BSCTAP_IR_REGWR    4'ha
`define BSCTAP_IR_CAPTURE  4'h1

// data register lengths in bits
`define BSCTAP_LEN_BYPASS  6'h01
`define BSCTAP_LEN_BSR     6'h18
`define BSCTAP_LEN_CODE    6'h20
`define BSCTAP_LEN_IFONOFF 6'h01
`define BSCTAP_LEN_REGRD   6'h08
`define BSCTAP_LEN_REGWR   6'h0f

// boundary chain and register access layout
`define BSCTAP_CELLS       24
`define BSCTAP_PADS        12
`define BSCTAP_DR_W        32
`define BSCTAP_ADDR_W      7
`define BSCTAP_DATA_W      8
`define BSCTAP_EXTRA_CELL  7
`define BSCTAP_EXTRA_PAD   4
`define BSCTAP_INPUT_PAD   3

`endif

// File: hw/bsctap_sync.v
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser; resets high to match the pull-ups on the pins
module bsctap_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta <= {W{1'b1}};
      q    <= {W{1'b1}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// File: tb/bsctap_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bsctap_checker (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       tdo,
  input wire logic       tdo_oe,
  input wire logic       host_if_off,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_we
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  logic [2:0] high_cnt;
  // saturates so a long high run keeps the reset claim alive
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      high_cnt <= 3'h0;
    end else if ($rose(tck)) begin
      if (!tms) begin
        high_cnt <= 3'h0;
      end else if (high_cnt != 3'h7) begin
        high_cnt <= high_cnt + 3'h1;
      end
    end
  end
  sequence tck_still;
    $stable(tck) [*8];
  endsequence
  sequence upd_change;
    $changed(reg_addr) || $changed(reg_wdata) || $changed(host_if_off);
  endsequence
  AST_TDO_IDLE: assert property (!tdo_oe |-> !tdo)
    else $error("tdo high while undriven");
  AST_TDO_LOW: assert property ($changed(tdo) || $changed(tdo_oe) |-> !tck)
    else $error("tdo moved while tck high");
  AST_OE_HOLD: assert property ($rose(tdo_oe) |=> tdo_oe [*6])
    else $error("tdo enable too short");
  AST_STILL: assert property (tck_still |-> $stable(tdo) && $stable(tdo_oe)
    && $stable(host_if_off) && $stable(reg_addr) && !reg_we)
    else $error("state moved with tck still");
  AST_UPD_LOW: assert property (upd_change |-> !tck && !tdo_oe)
    else $error("update outside update state");
  AST_WE_PULSE: assert property (reg_we |=> !reg_we)
    else $error("write strobe too long");
  AST_WE_ON: assert property (reg_we |-> host_if_off && !tck)
    else $error("write while access off");
  AST_FIVE: assert property (high_cnt >= 3'h5 |-> !tdo_oe && !reg_we)
    else $error("no reset after five highs");
endmodule
bind bsctap_top bsctap_checker bsctap_checker_inst (
  .clk_sys(clk_sys), .nrst(nrst), .tck(tck), .tms(tms), .tdo(tdo),
  .tdo_oe(tdo_oe), .host_if_off(host_if_off), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we));
`default_nettype wire

// File: tb/bsctap_tester.sv
`timescale 1ns/100ps
`default_nettype none
module bsctap_tester (
  input  wire logic clk_sys,
  output var logic  tck,
  output var logic  tms,
  output var logic  tdi,
  input  wire logic tdo
);
  int hi_wait;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    hi_wait = 2;
  end
  // tck parks low between frames; tdo read mid-high, well past its update
  task automatic bit_io(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk_sys);
    tck = 1'b1;
    // a longer high phase parks the test clock mid-frame
    repeat (hi_wait) @(negedge clk_sys);
    o = tdo;
    repeat (2) @(negedge clk_sys);
    tck = 1'b0;
  endtask
  // idle to idle; ir picks the instruction path, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    bit_io(1'b1, 1'b1, o);
    if (ir) bit_io(1'b1, 1'b1, o);
    bit_io(1'b0, 1'b1, o);
    bit_io(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], dout[i]);
    end
    bit_io(1'b1, 1'b1, o);
    bit_io(1'b0, 1'b1, o);
  endtask
endmodule
`default_nettype wire

// File: tb/bsctap_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module bsctap_top_tb;
  localparam logic [31:0] ID_EXP = {4'h3, 16'h1234, 11'h155, 1'b1};
  localparam logic [31:0] USER = 32'h1a2b3c4d;
  localparam logic [31:0] PRE = 32'h000000cc;
  localparam logic [9:0]  RST_SEQ = 10'b0111110011;
  logic        clk_sys;
  logic        nrst;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic [11:0] pad_out;
  logic [11:0] pad_oe;
  logic        host_if_off;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_we;
  logic [7:0]  reg_rdata;
  logic [31:0] dout;
  logic [11:0] core_out;
  logic [11:0] core_oe;
  logic [11:0] pad_in;
  logic        bit_o;
  int          err_total;
  int          checks;
  int          we_seen;
  // id values are arbitrary
  bsctap_top #(.ID_VERSION(4'h3), .ID_PART(16'h1234), .ID_MAKER(11'h155))
    bsctap_top_inst (.clk_sys(clk_sys), .nrst(nrst), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out),
    .core_oe(core_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .user_id_bytes(USER), .host_if_off(host_if_off), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata));
  bsctap_tester bsctap_tester_inst (.clk_sys(clk_sys), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo));
  assign reg_rdata = {1'b0, reg_addr} ^ 8'ha5;
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (reg_we === 1'b1) we_seen++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic sc(input logic ir, input int n, input logic [31:0] din);
    bsctap_tester_inst.scan(ir, n, din, dout);
  endtask
  task automatic t_ident();
    sc(1'b0, 32, 32'h0);
    check(dout, ID_EXP);
    sc(1'b1, 4, 32'h3);
    check(dout, 32'h1);
    sc(1'b0, 32, 32'h0);
    check(dout, USER);
    check(tdo_oe, 0);
  endtask
  task automatic t_bypass(input logic [3:0] code, input logic [23:0] pads);
    sc(1'b1, 4, {28'h0, code});
    sc(1'b0, 8, 32'hb6);
    check(dout, 32'h6c);
    check({pad_oe, pad_out}, pads);
  endtask
  task automatic t_bsr();
    sc(1'b1, 4, 32'h1);
    sc(1'b0, 24, PRE);
    check(dout, 32'h05fa91);
    sc(1'b1, 4, 32'h7);
    check({pad_oe, pad_out}, 24'h00201a);
    pad_in = 12'hc3a;
    sc(1'b0, 24, PRE);
    check(dout, 32'h50afc4);
    pad_in = 12'h3c5;
    t_bypass(4'h4, 24'h00201a);
    t_bypass(4'h5, 24'h0005b3);
  endtask
  task automatic t_rst_mid();
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({tdo_oe, host_if_off, reg_addr, reg_wdata}, 0);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    bsctap_tester_inst.bit_io(1'b0, 1'b1, bit_o);
    sc(1'b0, 32, 32'h0);
    check(dout, ID_EXP);
  endtask
  task automatic t_still();
    bsctap_tester_inst.hi_wait = 12;
    sc(1'b0, 32, 32'h0);
    bsctap_tester_inst.hi_wait = 2;
    check(dout, ID_EXP);
  endtask
  task automatic t_regs();
    sc(1'b1, 4, 32'ha);
    sc(1'b0, 15, {17'h0, 8'h3c, 7'h55});
    check(we_seen + reg_addr, 0);
    sc(1'b1, 4, 32'h8);
    sc(1'b0, 1, 32'h1);
    check(host_if_off, 1);
    sc(1'b1, 4, 32'ha);
    sc(1'b0, 15, {17'h0, 8'h3c, 7'h55});
    check({we_seen[7:0], reg_wdata, 1'b0, reg_addr}, 24'h013c55);
    sc(1'b1, 4, 32'h9);
    sc(1'b0, 8, 32'h21);
    check(dout, 32'hf0);
    check(reg_addr, 7'h21);
  endtask
  task automatic t_reset5();
    sc(1'b1, 4, 32'h0);
    // into shift-ir, then five highs pass update-ir and must end in reset
    for (int i = 0; i < 10; i++) begin
      bsctap_tester_inst.bit_io(RST_SEQ[i], 1'b1, bit_o);
    end
    sc(1'b0, 32, 32'h0);
    check(dout, ID_EXP);
  endtask
  initial begin
    nrst = 1'b0;
    err_total = 0;
    checks = 0;
    we_seen = 0;
    core_out = 12'h5b3;
    core_oe = 12'h0f0;
    pad_in = 12'h3c5;
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    // leave test-logic-reset so the scans start from idle
    bsctap_tester_inst.bit_io(1'b0, 1'b1, bit_o);
    t_ident();
    t_bypass(4'h0, 24'h0f05b3);
    t_bypass(4'h6, 24'h0f05b3);
    t_bypass(4'hf, 24'h0f05b3);
    t_bsr();
    t_regs();
    t_rst_mid();
    t_reset5();
    t_still();
    end_sim();
  end
  initial begin
    #500000;
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire
